/* src/dpm_host_pkg.sv */
// Constants, timing figures and carrier types for the dual-port memory port controller.
// Assumes a single core clock whose period is given below; pins sampled synchronously.
package dpm_host_pkg;

  // ----------------------------------------------------------------
  // Geometry and clock
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 8000;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam int SEM_IDX_W = 3;
  localparam int SEM_COUNT = 8;
  localparam int TMR_W = 4;

  // Mailbox words at the top of the array
  localparam logic [ADDR_W-1:0] LEFT_MAIL_ADDR = 12'hFFE;
  localparam logic [ADDR_W-1:0] RIGHT_MAIL_ADDR = 12'hFFF;
  localparam logic [DATA_W-1:0] SEM_FREE_DATA = 8'hFF;

  // ----------------------------------------------------------------
  // Pin timing in ns
  // ----------------------------------------------------------------
  localparam int FLAG_DELAY_FROM_MATCH_NS = 15;
  localparam int FLAG_DELAY_FROM_SELECT_NS = 15;
  localparam int FLAG_UPDATE_PULSE_TIME_NS = 10;
  localparam int FLAG_WRITE_TO_READ_TIME_NS = 5;
  localparam int OUTPUT_ENABLE_ACCESS_TIME_NS = 15;
  localparam int READ_ACCESS_NS = 15;
  localparam int WRITE_PULSE_NS = 12;

  // Least time in ns to whole clock cycles, never below one
  function automatic int cycles_up(input int ns);
    int c;
    c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction : cycles_up

  localparam int BUSY_SETTLE_CYC = cycles_up((FLAG_DELAY_FROM_MATCH_NS > FLAG_DELAY_FROM_SELECT_NS) ?
                                             FLAG_DELAY_FROM_MATCH_NS : FLAG_DELAY_FROM_SELECT_NS);
  localparam int WRITE_PULSE_CYC = cycles_up(WRITE_PULSE_NS);
  localparam int WRITE_HOLD_CYC = 1;
  localparam int READ_CYC = cycles_up(READ_ACCESS_NS);
  localparam int FLAG_GAP_CYC = cycles_up(FLAG_UPDATE_PULSE_TIME_NS);
  localparam int SEM_READBACK_CYC = cycles_up(FLAG_WRITE_TO_READ_TIME_NS + OUTPUT_ENABLE_ACCESS_TIME_NS);

  // ----------------------------------------------------------------
  // Commands
  // ----------------------------------------------------------------
  localparam logic [2:0] OP_MEM_RD = 3'h0;
  localparam logic [2:0] OP_MEM_WR = 3'h1;
  localparam logic [2:0] OP_SEM_RD = 3'h2;
  localparam logic [2:0] OP_SEM_WR = 3'h3;
  localparam logic [2:0] OP_SEM_TAKE = 3'h4;
  localparam logic [2:0] OP_MAIL_POST = 3'h5;
  localparam logic [2:0] OP_MAIL_TAKE = 3'h6;

  typedef struct packed {
    logic [2:0] op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } cmd_t;

  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic grant;
  } rsp_t;

  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic wr_n;
    logic sem_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq;
    logic dq_oe;
  } pin_out_t;

  localparam pin_out_t PIN_IDLE = '{ce_n: 1'b1, oe_n: 1'b1, wr_n: 1'b1, sem_n: 1'b1,
                                    addr: 12'h000, dq: 8'h00, dq_oe: 1'b0};

endpackage : dpm_host_pkg

/* src/dpm_wait_timer.sv */
// Down counter that times pin phases of the port controller.
// Assumes load values of at least one; done is high once the count has run out.
`timescale 1ns/1ps
module dpm_wait_timer #(
  parameter int W = 4
) (
  input wire logic clk, // Core clock
  input wire logic arst_n, // Asynchronous reset, low active
  input wire logic load, // Start a new wait
  input wire logic [W-1:0] load_val, // Cycles to wait
  output logic done // Wait has run out
);
  import dpm_host_pkg::*;

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  if (W < 1 || W > 16)
  begin : g_chk
    $error("Timer width out of range");
  end

  typedef struct packed {
    logic [W-1:0] cnt;
  } tmr_t;

  tmr_t q;
  tmr_t d;

  // Load or count down to zero
  always_comb
  begin
    d = q;
    if (load)
    begin
      d.cnt = load_val;
    end
    else if (q.cnt != '0)
    begin
      d.cnt = q.cnt - {{(W-1){1'b0}}, 1'b1};
    end
  end

  // State register
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign done = (q.cnt == '0);

endmodule : dpm_wait_timer

/* src/dpm_port_host.sv */
// Controller that drives one port of an asynchronous dual-port memory with
// mailbox flags, busy arbitration and eight semaphore latches.
// Assumes memory pins are sampled synchronously to CORE_CLK; the other port is
// driven by an independent controller.
// Summary of operation
// - Delay write until busy input has settled
// - Semaphore access: select low, chip select high
// - Deselect for pulse time before semaphore readback
// - Write one to every semaphore after reset
// - Selects decode access; both low is illegal
`timescale 1ns/1ps
module dpm_port_host #(
  parameter bit IS_LEFT = 1'b1 // Port side this controller drives
) (
  input wire logic CORE_CLK, // Core clock
  input wire logic ARST_N, // Asynchronous reset, low active
  input wire logic CMD_VALID, // Command offered
  input wire dpm_host_pkg::cmd_t CMD, // Operation, address, write data
  output logic CMD_READY, // Command accepted while high
  output logic RSP_VALID, // Command finished, one-cycle pulse
  output dpm_host_pkg::rsp_t RSP, // Read data and semaphore grant
  output logic MAIL_PEND, // Mailbox flag of this port is set
  output dpm_host_pkg::pin_out_t PIN_OUT, // Memory control, address and data drive
  input wire logic [dpm_host_pkg::DATA_W-1:0] PIN_DQ_IN, // Memory data lines
  input wire logic BUSY_N_IN, // Busy flag of this port, low active
  input wire logic INT_N_IN // Mailbox flag of this port, low active
);
  import dpm_host_pkg::*;

  // ----------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------
  if (BUSY_SETTLE_CYC >= (1 << TMR_W) || WRITE_PULSE_CYC >= (1 << TMR_W) || READ_CYC >= (1 << TMR_W) ||
      FLAG_GAP_CYC >= (1 << TMR_W) || SEM_READBACK_CYC >= (1 << TMR_W))
  begin : g_chk
    $error("Phase count exceeds timer width");
  end

  localparam logic [TMR_W-1:0] T_SETTLE = TMR_W'(BUSY_SETTLE_CYC);
  localparam logic [TMR_W-1:0] T_PULSE = TMR_W'(WRITE_PULSE_CYC);
  localparam logic [TMR_W-1:0] T_HOLD = TMR_W'(WRITE_HOLD_CYC);
  localparam logic [TMR_W-1:0] T_READ = TMR_W'(READ_CYC);
  localparam logic [TMR_W-1:0] T_GAP = TMR_W'(FLAG_GAP_CYC);
  localparam logic [TMR_W-1:0] T_SEMRD = TMR_W'(SEM_READBACK_CYC);
  localparam logic [ADDR_W-1:0] POST_ADDR = IS_LEFT ? RIGHT_MAIL_ADDR : LEFT_MAIL_ADDR;
  localparam logic [ADDR_W-1:0] OWN_ADDR = IS_LEFT ? LEFT_MAIL_ADDR : RIGHT_MAIL_ADDR;
  localparam logic [SEM_IDX_W-1:0] SEM_LAST = SEM_IDX_W'(SEM_COUNT - 1);

  typedef enum logic [5:0] {
    S_IDLE = 6'h01,
    S_SETUP = 6'h02,
    S_STROBE = 6'h04,
    S_HOLD = 6'h08,
    S_GAP = 6'h10,
    S_READ = 6'h20
  } state_t;

  typedef struct packed {
    state_t st;
    pin_out_t pin;
    cmd_t cur;
    logic init_busy;
    logic [SEM_IDX_W-1:0] init_idx;
    logic cmd_ready;
    logic rsp_valid;
    rsp_t rsp;
    logic mail_pend;
  } ctl_t;

  localparam ctl_t RST_VAL = '{st: S_IDLE, pin: PIN_IDLE, cur: '0, init_busy: 1'b1, init_idx: '0,
                               cmd_ready: 1'b0, rsp_valid: 1'b0, rsp: '0, mail_pend: 1'b0};

  ctl_t q;
  ctl_t d;
  logic tmr_load;
  logic [TMR_W-1:0] tmr_val;
  logic tmr_done;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic is_sem(input logic [2:0] op);
    return (op == OP_SEM_RD) || (op == OP_SEM_WR) || (op == OP_SEM_TAKE);
  endfunction : is_sem

  function automatic logic is_write(input logic [2:0] op);
    return (op == OP_MEM_WR) || (op == OP_SEM_WR) || (op == OP_SEM_TAKE) || (op == OP_MAIL_POST);
  endfunction : is_write

  // Present address and one select; the other select stays high
  function automatic pin_out_t select_pins(input cmd_t c);
    pin_out_t p;
    p = PIN_IDLE;
    p.sem_n = ~is_sem(c.op);
    p.ce_n = is_sem(c.op);
    if (is_sem(c.op))
    begin
      p.addr = {{(ADDR_W-SEM_IDX_W){1'b0}}, c.addr[SEM_IDX_W-1:0]};
    end
    else
    begin
      p.addr = c.addr;
    end
    return p;
  endfunction : select_pins

  // ----------------------------------------------------------------
  // Timer
  // ----------------------------------------------------------------
  dpm_wait_timer #(
    .W(TMR_W)
  ) u_timer (
    .clk(CORE_CLK),
    .arst_n(ARST_N),
    .load(tmr_load),
    .load_val(tmr_val),
    .done(tmr_done)
  );

  // Sequencer for memory, semaphore and mailbox accesses
  always_comb
  begin
    d = q;
    tmr_load = 1'b0;
    tmr_val = '0;
    d.rsp_valid = 1'b0;
    d.mail_pend = ~INT_N_IN;
    case (q.st)
      S_IDLE:
      begin
        if (q.init_busy)
        begin
          // Free every latch from this side after reset
          d.cur.op = OP_SEM_WR;
          d.cur.addr = {{(ADDR_W-SEM_IDX_W){1'b0}}, q.init_idx};
          d.cur.data = SEM_FREE_DATA;
          d.pin = select_pins(d.cur);
          d.st = S_SETUP;
          tmr_load = 1'b1;
          tmr_val = T_SETTLE;
        end
        else if (CMD_VALID && q.cmd_ready)
        begin
          d.cur = CMD;
          if (CMD.op == OP_MAIL_POST)
          begin
            d.cur.op = OP_MEM_WR;
            d.cur.addr = POST_ADDR;
          end
          else if (CMD.op == OP_MAIL_TAKE)
          begin
            d.cur.op = OP_MEM_RD;
            d.cur.addr = OWN_ADDR;
          end
          d.pin = select_pins(d.cur);
          d.cmd_ready = 1'b0;
          d.st = S_SETUP;
          tmr_load = 1'b1;
          tmr_val = T_SETTLE;
        end
      end
      S_SETUP:
      begin
        // Memory accesses wait for the busy flag to settle and release
        if (tmr_done && (is_sem(q.cur.op) || BUSY_N_IN))
        begin
          tmr_load = 1'b1;
          if (is_write(q.cur.op))
          begin
            d.pin.wr_n = 1'b0;
            d.pin.dq = q.cur.data;
            d.pin.dq_oe = 1'b1;
            d.st = S_STROBE;
            tmr_val = T_PULSE;
          end
          else
          begin
            d.pin.oe_n = 1'b0;
            d.st = S_READ;
            tmr_val = T_READ;
          end
        end
      end
      S_STROBE:
      begin
        // Raise the strobe first; select and data held one more phase
        if (tmr_done)
        begin
          d.pin.wr_n = 1'b1;
          d.st = S_HOLD;
          tmr_load = 1'b1;
          tmr_val = T_HOLD;
        end
      end
      S_HOLD:
      begin
        if (tmr_done)
        begin
          d.pin = PIN_IDLE;
          tmr_load = 1'b1;
          if (q.cur.op == OP_SEM_TAKE)
          begin
            d.st = S_GAP;
            tmr_val = T_GAP;
          end
          else
          begin
            d.st = S_IDLE;
            d.rsp.grant = 1'b0;
            if (q.init_busy)
            begin
              d.init_idx = q.init_idx + {{(SEM_IDX_W-1){1'b0}}, 1'b1};
              d.init_busy = (q.init_idx != SEM_LAST);
              d.cmd_ready = (q.init_idx == SEM_LAST);
            end
            else
            begin
              d.rsp_valid = 1'b1;
              d.cmd_ready = 1'b1;
            end
          end
        end
      end
      S_GAP:
      begin
        // Select deasserted for the flag update time, then read back
        if (tmr_done)
        begin
          d.cur.op = OP_SEM_RD;
          d.pin = select_pins(d.cur);
          d.pin.oe_n = 1'b0;
          d.st = S_READ;
          tmr_load = 1'b1;
          tmr_val = T_SEMRD;
        end
      end
      S_READ:
      begin
        if (tmr_done)
        begin
          d.rsp.data = PIN_DQ_IN;
          d.rsp.grant = is_sem(q.cur.op) && !PIN_DQ_IN[0];
          d.pin = PIN_IDLE;
          d.rsp_valid = 1'b1;
          d.cmd_ready = 1'b1;
          d.st = S_IDLE;
        end
      end
      default:
      begin
        d = RST_VAL;
      end
    endcase
  end

  // State register
  always_ff @(posedge CORE_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      q <= RST_VAL;
    end
    else
    begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs straight from the state register
  // ----------------------------------------------------------------
  assign CMD_READY = q.cmd_ready;
  assign RSP_VALID = q.rsp_valid;
  assign RSP = q.rsp;
  assign MAIL_PEND = q.mail_pend;
  assign PIN_OUT = q.pin;

endmodule : dpm_port_host

/* verification/dpm_port_checker.sv */
// Pin checker for the port controller.
// Assumes it is bound onto dpm_port_host.
`timescale 1ns/1ps
module dpm_port_checker
  import dpm_host_pkg::*;
(
  input wire logic CORE_CLK, // Clock
  input wire logic ARST_N, // Reset, low active
  input wire logic MAIL_PEND, // Mailbox pending
  input wire dpm_host_pkg::pin_out_t PIN_OUT, // Memory pins
  input wire logic BUSY_N_IN, // Busy, low active
  input wire logic INT_N_IN // Mailbox flag, low active
);
  // ----
  // Pin relations
  // ----
  default clocking @(posedge CORE_CLK);
  endclocking
  default disable iff (!ARST_N);

  // Decode, strobes, busy hold-off and mailbox flag copy
  a_sel_excl: assert property (!(!PIN_OUT.ce_n && !PIN_OUT.sem_n))
    else $error("both selects low");
  a_wr_in_sel: assert property (!PIN_OUT.wr_n |-> !(PIN_OUT.ce_n && PIN_OUT.sem_n))
    else $error("write strobe without select");
  a_drive_in_sel: assert property (PIN_OUT.dq_oe |-> !(PIN_OUT.ce_n && PIN_OUT.sem_n))
    else $error("data driven while deselected");
  a_sem_low_addr: assert property (!PIN_OUT.sem_n |-> PIN_OUT.addr[11:3] == 9'h000)
    else $error("latch access with upper address set");
  a_busy_write: assert property (($fell(PIN_OUT.wr_n) && !PIN_OUT.ce_n) |-> $past(BUSY_N_IN))
    else $error("write started while busy");
  a_busy_read: assert property (($fell(PIN_OUT.oe_n) && !PIN_OUT.ce_n) |-> $past(BUSY_N_IN))
    else $error("read started while busy");
  a_mail_copy: assert property ($past(ARST_N) |-> MAIL_PEND == !$past(INT_N_IN))
    else $error("mailbox pending not following flag");
  // Readback opens select and output enable together; select must have been off two cycles before
  a_sem_gap: assert property (($fell(PIN_OUT.sem_n) && !PIN_OUT.oe_n) |-> $past(PIN_OUT.sem_n, 2))
    else $error("latch select gap too short");
endmodule : dpm_port_checker

bind dpm_port_host dpm_port_checker u_dpm_port_checker (.CORE_CLK(CORE_CLK), .ARST_N(ARST_N),
  .MAIL_PEND(MAIL_PEND), .PIN_OUT(PIN_OUT), .BUSY_N_IN(BUSY_N_IN), .INT_N_IN(INT_N_IN));

/* verification/dpm_mem_model.sv */
// Behavioural dual-port memory seen from the left port.
// Assumes registered left pins; the bench acts for the right port.
`timescale 1ns/1ps
module dpm_mem_model
  import dpm_host_pkg::*;
(
  input wire logic clk, // Clock
  input wire dpm_host_pkg::pin_out_t pin, // Left pins
  output logic [7:0] dq, // Resolved left data lines
  output logic busy_n, // Left busy
  output logic mail_l_n // Left mailbox flag
);
  logic [7:0] mem [4096];
  logic [1:0] own [8];
  logic [1:0] pend [8];
  logic mail_r_n, r_hold, wq, ws, rdq;
  logic [11:0] r_addr, wa;
  logic [7:0] wd, semq, last, cur;
  wire sel = !pin.ce_n || !pin.sem_n;
  wire rd = sel && !pin.oe_n && pin.wr_n;

  // Stale state at power-up, left owns all latches
  initial
  begin
    for (int i = 0; i < 8; i++)
    begin
      own[i] = 2'b01;
      pend[i] = 2'b00;
    end
    {mail_r_n, mail_l_n, r_hold, wq, ws, rdq, last} = {6'h33, 8'h00};
    r_addr = 12'h000;
  end

  // Request or release one latch for one side
  task automatic sem_wr(input int s, input int i, input logic b);
    logic [1:0] me;
    me = 2'(s + 1);
    if (!b && own[i] == 2'b00)
      own[i] = me;
    else if (!b && own[i] != me)
      pend[i][s] = 1'b1;
    else if (b)
    begin
      pend[i][s] = 1'b0;
      if (own[i] == me)
      begin
        own[i] = pend[i][1-s] ? 2'(3 - me) : 2'b00;
        pend[i][1-s] = 1'b0;
      end
    end
  endtask : sem_wr

  // Right port memory accesses
  task automatic r_mem_wr(input logic [11:0] a, input logic [7:0] d);
    mem[a] = d;
    if (a == 12'hFFE)
      mail_l_n = 1'b0;
  endtask : r_mem_wr

  task automatic r_mem_rd(input logic [11:0] a, output logic [7:0] d);
    d = mem[a];
    if (a == 12'hFFF)
      mail_r_n = 1'b1;
  endtask : r_mem_rd

  function automatic logic rview(input int i);
    return own[i] != 2'b10;
  endfunction : rview

  // Line levels; released lines toggle
  assign cur = {8{own[pin.addr[2:0]] != 2'b01}};
  assign dq = pin.dq_oe ? pin.dq : !rd ? ~last : !pin.sem_n ? (rdq ? semq : cur) : mem[pin.addr];
  assign busy_n = !(r_hold && !pin.ce_n && pin.addr == r_addr);

  // Left write commit, read latch and mailbox clear
  always @(posedge clk)
  begin
    if (wq && !(sel && !pin.wr_n))
    begin
      if (ws)
        sem_wr(0, int'(wa[2:0]), wd[0]);
      else
      begin
        mem[wa] = wd;
        if (wa == 12'hFFF)
          mail_r_n = 1'b0;
      end
    end
    if (rd && !pin.ce_n && pin.addr == 12'hFFE)
      mail_l_n <= 1'b1;
    semq <= rdq ? semq : cur;
    {wq, ws, rdq, wa, wd, last} <= {sel && !pin.wr_n, !pin.sem_n, rd, pin.addr, dq, dq};
  end
endmodule : dpm_mem_model

/* verification/dpm_port_host_tb.sv */
// Bench for the port controller on the left port of a memory model.
// Assumes the right port is played through model tasks.
`timescale 1ns/1ps
module dpm_port_host_tb;
  import dpm_host_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cv = 1'b0;
  cmd_t c = '0;
  logic rdy, rv, pend, busy_n, mail_n;
  rsp_t rsp, r;
  pin_out_t pin;
  logic [7:0] dq_in;
  int err_total = 0;
  int cmp_count = 0;

  dpm_port_host #(.IS_LEFT(1'b1)) u_dpm_port_host (.CORE_CLK(clk), .ARST_N(rst_n), .CMD_VALID(cv), .CMD(c),
    .CMD_READY(rdy), .RSP_VALID(rv), .RSP(rsp), .MAIL_PEND(pend), .PIN_OUT(pin), .PIN_DQ_IN(dq_in),
    .BUSY_N_IN(busy_n), .INT_N_IN(mail_n));
  dpm_mem_model u_dpm_mem_model (.clk(clk), .pin(pin), .dq(dq_in), .busy_n(busy_n), .mail_l_n(mail_n));

  // Clock
  initial
  begin
    forever #4 clk = ~clk;
  end

  // ----
  // Shared tasks
  // ----
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wait_for(ref logic s);
    int n;
    n = 0;
    while (s !== 1'b1 && n < 400)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    chk({7'h0, s}, 8'h01);
  endtask : wait_for

  task automatic cmd(input logic [2:0] op, input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    c = '{op: op, addr: a, data: d};
    cv = 1'b1;
    wait_for(rdy);
    @(posedge clk);
    #1;
    cv = 1'b0;
    wait_for(rv);
    r = rsp;
  endtask : cmd

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : close_out

  // ----
  // Scenarios
  // ----
  task automatic t_init();
    wait_for(rdy);
    for (int i = 0; i < 8; i++)
    begin
      u_dpm_mem_model.sem_wr(1, i, 1'b1);
      cmd(OP_SEM_RD, 12'(i), 8'h00);
      chk(r.data, SEM_FREE_DATA);
    end
    $display("init done");
  endtask : t_init

  task automatic t_mem();
    cmd(OP_MEM_WR, 12'h123, 8'hA5);
    cmd(OP_MEM_RD, 12'h123, 8'h00);
    chk(r.data, 8'hA5);
    chk({7'h0, r.grant}, 8'h00);
    $display("memory done");
  endtask : t_mem

  task automatic t_mail();
    logic [7:0] d;
    cmd(OP_MAIL_POST, RIGHT_MAIL_ADDR, 8'h3C);
    chk({7'h0, u_dpm_mem_model.mail_r_n}, 8'h00);
    u_dpm_mem_model.r_mem_rd(12'hFFF, d);
    chk(d, 8'h3C);
    chk({7'h0, u_dpm_mem_model.mail_r_n}, 8'h01);
    u_dpm_mem_model.r_mem_wr(12'hFFE, 8'hC3);
    repeat (2) @(posedge clk);
    #1;
    chk({7'h0, pend}, 8'h01);
    cmd(OP_MAIL_TAKE, LEFT_MAIL_ADDR, 8'h00);
    chk(r.data, 8'hC3);
    repeat (2) @(posedge clk);
    #1;
    chk({7'h0, pend}, 8'h00);
    $display("mailbox done");
  endtask : t_mail

  task automatic t_sem();
    cmd(OP_SEM_TAKE, 12'hAB3, 8'hFE);
    chk({7'h0, r.grant}, 8'h01);
    chk({7'h0, u_dpm_mem_model.rview(3)}, 8'h01);
    u_dpm_mem_model.sem_wr(1, 3, 1'b0);
    cmd(OP_SEM_RD, 12'h003, 8'h00);
    chk(r.data, 8'h00);
    cmd(OP_SEM_WR, 12'h003, 8'h01);
    chk({7'h0, u_dpm_mem_model.rview(3)}, 8'h00);
    cmd(OP_SEM_TAKE, 12'h003, 8'h00);
    chk(r.data, 8'hFF);
    u_dpm_mem_model.sem_wr(1, 3, 1'b1);
    cmd(OP_SEM_RD, 12'h003, 8'h00);
    chk(r.data, 8'h00);
    cmd(OP_SEM_WR, 12'h003, 8'h01);
    cmd(OP_SEM_RD, 12'h003, 8'h00);
    chk(r.data, 8'hFF);
    chk({7'h0, u_dpm_mem_model.rview(3)}, 8'h01);
    $display("latches done");
  endtask : t_sem

  task automatic t_busy();
    u_dpm_mem_model.r_mem_wr(12'h055, 8'h11);
    u_dpm_mem_model.r_addr = 12'h055;
    u_dpm_mem_model.r_hold = 1'b1;
    fork
      cmd(OP_MEM_WR, 12'h055, 8'h66);
      begin
        repeat (20) @(posedge clk);
        #1;
        chk(u_dpm_mem_model.mem[12'h055], 8'h11);
        u_dpm_mem_model.r_hold = 1'b0;
      end
    join
    chk(u_dpm_mem_model.mem[12'h055], 8'h66);
    $display("busy done");
  endtask : t_busy

  // Main sequence
  initial
  begin
    repeat (3) @(posedge clk);
    #1;
    rst_n = 1'b1;
    t_init();
    t_mem();
    t_mail();
    t_sem();
    t_busy();
    close_out();
  end

  // Watchdog
  initial
  begin
    #40000;
    err_total++;
    close_out();
  end
endmodule : dpm_port_host_tb
